// ===== core/vrlc_pkg.sv
// Functional notes
// - A one in the enable field (bit 7) powers the ladder up, a zero powers it down.
// - A one in the pin output field (bit 6) routes the reference to its pin, a zero cuts it off.
// - A one in the range field (bit 5) gives the low range: level code times span over 24.
// - A zero in the range field gives the high range: span over 4 plus level code times span over 32.
// - The source field (bit 4) picks the external reference pins when one, the supply rails when zero.
// - The tap level is the 4-bit code in bits 3 to 0, from 0 to 15.
// - While the pin output field is set, the shared pin's direction bit is ignored.
// - Any reset clears the control register: off, disconnected, high range, level zero.
// - Waking from sleep leaves the control register unchanged.
// - The reference works whatever the comparator configuration is.
package vrlc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] VRLC_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] VRLC_CTRL_RESET = 8'h00;
    localparam int VRLC_EN_BIT = 7;
    localparam int VRLC_OE_BIT = 6;
    localparam int VRLC_RANGE_BIT = 5;
    localparam int VRLC_SRC_BIT = 4;
    localparam int VRLC_LEVEL_MSB = 3;
    localparam int VRLC_TAP_W = 5;
    // high range ladder tap base; high range starts a quarter up the 32-step ladder
    localparam logic [4:0] VRLC_HIGH_BASE = 5'h08;
    localparam logic [1:0] VRLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] VRLC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic power_on;
        logic pin_route;
        logic low_range;
        logic src_external;
        logic [3:0] level;
    } vrlc_ctrl_t;

    typedef struct packed {
        logic ladder_power;
        logic pin_connect;
        logic pin_dir_override;
        logic src_external;
        logic low_range;
        logic [3:0] level;
        logic [VRLC_TAP_W-1:0] tap;
    } vrlc_drive_t;

endpackage : vrlc_pkg

// ===== core/vrlc_tap.sv
`timescale 1ns/100ps
module vrlc_tap
    import vrlc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire vrlc_ctrl_t ctrl,
    output vrlc_drive_t drive
);

    // ****************************************
    // registered ladder controls
    // ****************************************
    function automatic logic [VRLC_TAP_W-1:0] tap_of(input vrlc_ctrl_t c);
        // low range steps of span/24 from zero; high range steps of span/32 from span/4
        if (c.low_range) begin
            tap_of = {1'b0, c.level};
        end else begin
            tap_of = VRLC_HIGH_BASE + {1'b0, c.level};
        end
    endfunction : tap_of

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // cleared register means high range at level zero, so the tap sits at the high base
            drive <= '0;
            drive.tap <= VRLC_HIGH_BASE;
        end else begin
            drive.ladder_power <= ctrl.power_on;
            drive.pin_connect <= ctrl.pin_route;
            drive.pin_dir_override <= ctrl.pin_route;
            drive.src_external <= ctrl.src_external;
            drive.low_range <= ctrl.low_range;
            drive.level <= ctrl.level;
            drive.tap <= tap_of(ctrl);
        end
    end

endmodule : vrlc_tap

// ===== core/vrlc_top.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module vrlc_top
    import vrlc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output vrlc_drive_t ladder
);

    // ****************************************
    // control register
    // ****************************************
    vrlc_ctrl_t ctrl;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic aw_held;
    logic w_held;
    logic do_write;

    function automatic logic hit(input logic [7:0] a);
        hit = (a[7:2] == VRLC_CTRL_OFFSET[7:2]);
    endfunction : hit

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // write address and data taken in either order, one write in flight
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // sleep and wake have no port here: only reset or a bus write changes the register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl <= vrlc_ctrl_t'(VRLC_CTRL_RESET);
        end else if (do_write && hit(aw_addr) && w_lane0) begin
            ctrl <= vrlc_ctrl_t'(w_data);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= VRLC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hit(aw_addr) ? VRLC_RESP_OKAY : VRLC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= VRLC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= hit(s_axi_araddr) ? {24'h00_0000, ctrl} : 32'h0000_0000;
            s_axi_rresp <= hit(s_axi_araddr) ? VRLC_RESP_OKAY : VRLC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // ladder drive
    // ****************************************
    // no comparator gating
    vrlc_tap u_tap (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ctrl(ctrl),
        .drive(ladder)
    );

    // ****************************************
    // checks
    // ****************************************
    a_ctrl_reset_value: assert property (@(posedge sys_clk)
        sys_rst |=> ctrl == VRLC_CTRL_RESET && ladder == vrlc_drive_t'({9'h000, VRLC_HIGH_BASE}))
        else $error("control not cleared by reset");

    a_power_follows_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 ladder.ladder_power == $past(ctrl.power_on))
        else $error("ladder power not following enable");

    a_pin_follows_oe: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 ladder.pin_connect == $past(ctrl.pin_route))
        else $error("pin route not following field");

    a_low_range_tap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrl.low_range |=> ladder.tap == {1'b0, $past(ctrl.level)})
        else $error("low range tap wrong");

    a_high_range_tap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ctrl.low_range |=> ladder.tap == VRLC_HIGH_BASE + {1'b0, $past(ctrl.level)})
        else $error("high range tap wrong");

    a_source_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 ladder.src_external == $past(ctrl.src_external))
        else $error("source select not following field");

    a_dir_override: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ladder.pin_dir_override == ladder.pin_connect)
        else $error("direction override differs from pin route");

    sequence s_write_lane0;
        do_write && hit(aw_addr) && w_lane0;
    endsequence

    a_write_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_write_lane0 |=> ctrl == $past(w_data) ##1 ladder.level == $past(ctrl.level))
        else $error("write did not reach ladder in two cycles");

    a_hold_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !do_write && !sys_rst |=> sys_rst || $stable(ctrl))
        else $error("control changed without write");

    a_bresp_after_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        do_write |=> s_axi_bvalid)
        else $error("no write response");

endmodule : vrlc_top

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import vrlc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0] shadow = 8'h00;
    logic [7:0] corners [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0f, 8'h2f, 8'hff, 8'h00};
    vrlc_drive_t ladder;
    int num_errors = 0;
    int checks = 0;

    vrlc_top dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ladder);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************
    // checking and reporting
    // ****************************************
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic note(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : note

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        note(got === exp, "response code");
    endtask : check_resp

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        note(got === exp, "read data");
    endtask : check_word

    // pin_dir_override follows the pin route bit: routing wins over the direction bit
    function automatic vrlc_drive_t exp_ladder(input logic [7:0] c);
        vrlc_drive_t d;
        d.ladder_power = c[7];
        d.pin_connect = c[6];
        d.pin_dir_override = c[6];
        d.low_range = c[5];
        d.src_external = c[4];
        d.level = c[3:0];
        d.tap = c[5] ? {1'b0, c[3:0]} : 5'h08 + {1'b0, c[3:0]};
        return d;
    endfunction : exp_ladder

    task automatic check_ladder();
        note(ladder === exp_ladder(shadow), "ladder drive");
    endtask : check_ladder

    // ****************************************
    // bus master
    // ****************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        if (s_axi_bvalid !== 1'b1) begin
            note(1'b0, "write timeout");
            tally_and_finish();
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        if (s_axi_rvalid !== 1'b1) begin
            note(1'b0, "read timeout");
            tally_and_finish();
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // ladder lags the register by one cycle, so two edges pass before looking
    task automatic settle_check();
        repeat (2) @(posedge sys_clk);
        check_ladder();
        axi_read(8'h00, rd, resp);
        check_word(rd, {24'h0, shadow});
        check_resp(resp, VRLC_RESP_OKAY);
    endtask : settle_check

    task automatic wr_check(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] exp_r);
        axi_write(a, d, s, resp);
        check_resp(resp, exp_r);
        if (a == 8'h00 && s[0]) shadow = d[7:0];
        settle_check();
    endtask : wr_check

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(41));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle_check();
        foreach (corners[i]) wr_check(8'h00, {24'h0, corners[i]}, 4'h1, VRLC_RESP_OKAY);
        repeat (24) wr_check(8'h00, $urandom(), 4'hf, VRLC_RESP_OKAY);
        wr_check(8'h00, 32'h0000005a, 4'he, VRLC_RESP_OKAY);
        wr_check(8'h04, 32'h000000a5, 4'hf, VRLC_RESP_SLVERR);
        axi_read(8'h08, rd, resp);
        check_word(rd, 32'h0);
        check_resp(resp, VRLC_RESP_SLVERR);
        repeat (20) @(posedge sys_clk);
        settle_check();
        wr_check(8'h00, 32'h000000ff, 4'h1, VRLC_RESP_OKAY);
        sys_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        shadow = 8'h00;
        settle_check();
        tally_and_finish();
    end
endmodule : tb_top
